// ---- rtl/swrt_pkg.sv ----
/*
 * swrt_pkg: register map, field layout, reset values, timing constants and
 * delay-code decoders for the sequencer wait and reset timing block.
 * Assumes a 40 MHz system clock; all times are converted to cycles here.
 */
package swrt_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] GATE_SLOT_SELECT_OFS      = 8'h92;
	localparam logic [7:0] RESERVED_A_OFS            = 8'h93;
	localparam logic [7:0] RESERVED_B_OFS            = 8'h94;
	localparam logic [7:0] DOMAIN_END_POINTERS_OFS   = 8'h95;
	localparam logic [7:0] PARTIAL_DOWN_POINTERS_OFS = 8'h96;
	localparam logic [7:0] GATE_CONTROL_OFS          = 8'h97;
	localparam logic [7:0] RESERVED_C_OFS            = 8'h98;
	localparam logic [7:0] RESET_RELEASE_TIMING_OFS  = 8'h99;
	localparam logic [7:0] SEQ_STATUS_OFS            = 8'hA0;

	// ****************************************
	// field positions
	// ****************************************
	localparam int HI_NIB_LSB       = 4;
	localparam int GATE_DIR_LSB     = 6;
	localparam int GATE_TIMEOUT_BIT = 5;
	localparam int GATE_KIND_BIT    = 4;
	localparam int RST_TRIG_LSB     = 6;
	localparam int DIR_UP_BIT       = 0;
	localparam int DIR_DOWN_BIT     = 1;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] GATE_SLOT_SELECT_RST      = 8'h00;
	localparam logic [7:0] DOMAIN_END_POINTERS_RST   = 8'h00;
	localparam logic [7:0] PARTIAL_DOWN_POINTERS_RST = 8'h00;
	localparam logic [7:0] GATE_CONTROL_RST          = 8'h00;
	localparam logic [7:0] RESET_RELEASE_TIMING_RST  = 8'h00;

	// ****************************************
	// reset timer trigger codes
	// ****************************************
	typedef enum logic [1:0] {
		SWRT_TRIG_WAKE, SWRT_TRIG_SYSTEM_DOMAIN_UP, SWRT_TRIG_POWER_DOMAIN_UP, SWRT_TRIG_LEAVE_RST
	} swrt_trig_e;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_PS      = 25000;
	localparam int SLOT_UNIT_NS       = 32000;
	localparam int GATE_UNIT_NS       = 512000;
	localparam int GATE_TIMEOUT_MS    = 500;
	localparam int RESET_UNIT_NS      = 1024000;
	localparam int RESET_HI_STEP      = 32;
	localparam int RESET_LINEAR_LAST  = 32;
	localparam int SLOT_UNIT_CYC      = (SLOT_UNIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int GATE_UNIT_CYC      = (GATE_UNIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RESET_UNIT_CYC     = (RESET_UNIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int GATE_TIMEOUT_CYC   = GATE_TIMEOUT_MS * (1000000000 / CLK_PERIOD_PS);
	localparam int UNITS_W            = 16;

	// ****************************************
	// delay-code decoders, results in timer units
	// ****************************************
	// slot time in 32 us units; step widens above code 8
	function automatic logic [UNITS_W-1:0] slot_units(input logic [3:0] code);
		logic [UNITS_W-1:0] u;
		u = 16'h0000;
		case (code)
			4'h9: u = 16'h000C;
			4'hA: u = 16'h000E;
			4'hB: u = 16'h0010;
			4'hC: u = 16'h0020;
			4'hD: u = 16'h0040;
			4'hE: u = 16'h0080;
			4'hF: u = 16'h0100;
			default: u = 16'({12'h000, code} + 16'h0001);
		endcase
		return u;
	endfunction

	// gate delay in 512 us units, doubling per code
	function automatic logic [UNITS_W-1:0] gate_units(input logic [3:0] code);
		logic [UNITS_W-1:0] u;
		u = 16'h0000;
		if (code != 4'h0) begin
			u = 16'h0001 << (code - 4'h1);
		end
		return u;
	endfunction

	// reset delay in 1.024 ms units: linear to 32, then 32-unit steps
	function automatic logic [UNITS_W-1:0] reset_units(input logic [5:0] code);
		logic [UNITS_W-1:0] u;
		u = {10'h000, code};
		if (code > 6'(RESET_LINEAR_LAST)) begin
			u = 16'((code - 6'(RESET_LINEAR_LAST - 1)) * RESET_HI_STEP);
		end
		return u;
	endfunction

endpackage

// ---- rtl/swrt_timer.sv ----
/*
 * swrt_timer: prescaled one-shot delay timer; a start loads a count of units,
 * done pulses one cycle after the last unit elapses.
 * Assumes start and abort are one-cycle pulses from the same clock domain.
 */
`timescale 1ns/1ps
module swrt_timer import swrt_pkg::*; #(
	parameter int UNIT_CYC = 1
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               resetn,
	// control
	input  wire logic               start,
	input  wire logic               abort,
	input  wire logic [UNITS_W-1:0] units,
	// status
	output logic                    busy_q,
	output logic                    done_q
);

	// ****************************************
	// counters
	// ****************************************
	logic [31:0]        pre_q;
	logic [UNITS_W-1:0] cnt_q;
	wire                unit_end = (pre_q == 32'(UNIT_CYC - 1));
	wire                last     = unit_end && (cnt_q == 16'h0001);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pre_q  <= 32'h0000_0000;
			cnt_q  <= 16'h0000;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else if (abort) begin
			pre_q  <= 32'h0000_0000;
			cnt_q  <= 16'h0000;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else if (start) begin
			// zero units finishes at once, no unit is spent
			pre_q  <= 32'h0000_0000;
			cnt_q  <= units;
			busy_q <= (units != 16'h0000);
			done_q <= (units == 16'h0000);
		end else if (busy_q) begin
			pre_q  <= unit_end ? 32'h0000_0000 : pre_q + 32'h0000_0001;
			cnt_q  <= unit_end ? cnt_q - 16'h0001 : cnt_q;
			busy_q <= !last;
			done_q <= last;
		end else begin
			done_q <= 1'b0;
		end
	end

endmodule

// ---- rtl/swrt_top.sv ----
/*
 * swrt_top: slot sequencer with a gate slot (pin or delay timer), domain end
 * and partial power-down pointers, and the reset-release delay timer.
 * Assumes all inputs synchronous to clk, requests and events as one-cycle
 * pulses, and a plain register port with read data one cycle later.
 */
// The plain strobed port was chosen for this implementation.
// Operation
// [R1] A 4-bit register field names the gate slot at which progress waits on the pin or a timer.
// [R2] The upper nibble ends the power domain and the lower nibble ends the system domain.
// [R3] The upper nibble marks where partial power-down stops, the lower ends the secondary domain.
// [R4] The direction field makes the gate slot wait never, on the way up, down, or both.
// [R5] With the timeout bit clear the pin wait is unlimited, when set it is cut at 500 ms.
// [R6] The kind bit chooses waiting for the pin to go active or for the delay timer to expire.
// [R7] The delay code gives zero at 0000 and 512 us doubling per step up to about 8.4 s.
// [R8] The trigger field starts the reset delay on wake, system up, power up or leaving reset.
// [R9] Software must not pick the leave-reset trigger while the reset output mode select is 1.
// [R10] The reset delay steps by 1.024 ms to 32.768 ms, then by 32.768 ms to 1048.576 ms.
// [R11] Slots are run in order, each lasting one slot duration, and each announces its number.
// [R12] The slot duration code runs from 32 us at 0000 to 8.192 ms at 1111.
// [R13] A gate timeout moves the sequencer on to the next slot instead of stalling.
`timescale 1ns/1ps
module swrt_top import swrt_pkg::*; #(
	parameter int SLOT_CYC    = SLOT_UNIT_CYC,
	parameter int GATE_CYC    = GATE_UNIT_CYC,
	parameter int TIMEOUT_CYC = GATE_TIMEOUT_CYC,
	parameter int RESET_CYC   = RESET_UNIT_CYC
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata_q,
	// sequencing requests and events
	input  wire logic       power_up_req,
	input  wire logic       power_down_req,
	input  wire logic       partial_down_req,
	input  wire logic       external_wake_event,
	input  wire logic       reset_state_exit,
	input  wire logic       slot_duration_code_in,
	input  wire logic [3:0] slot_duration_code,
	// gate pin
	input  wire logic       gate_input_pin,
	// sequencer outputs
	output logic      [3:0] slot_q,
	output logic            slot_step_q,
	output logic            seq_busy_q,
	output logic            seq_down_q,
	output logic            gate_waiting_q,
	output logic            gate_timeout_q,
	output logic            system_domain_up_q,
	output logic            power_domain_up_q,
	output logic            secondary_power_domain_up_q,
	output logic            reset_release_q
);

	// ****************************************
	// configuration registers
	// ****************************************
	logic [3:0] gate_slot_q;
	logic [7:0] domain_end_q;
	logic [7:0] partial_down_q;
	logic [7:0] gate_ctrl_q;
	logic [7:0] reset_timing_q;
	logic [3:0] slot_code_q;

	wire sel_gate_slot = (reg_addr == GATE_SLOT_SELECT_OFS);
	wire sel_dom_end   = (reg_addr == DOMAIN_END_POINTERS_OFS);
	wire sel_partial_shutdown_pointer = (reg_addr == PARTIAL_DOWN_POINTERS_OFS);
	wire sel_gate_ctrl = (reg_addr == GATE_CONTROL_OFS);
	wire sel_rst_time  = (reg_addr == RESET_RELEASE_TIMING_OFS);
	wire sel_status    = (reg_addr == SEQ_STATUS_OFS);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gate_slot_q    <= GATE_SLOT_SELECT_RST[3:0];
			domain_end_q   <= DOMAIN_END_POINTERS_RST;
			partial_down_q <= PARTIAL_DOWN_POINTERS_RST;
			gate_ctrl_q    <= GATE_CONTROL_RST;
			reset_timing_q <= RESET_RELEASE_TIMING_RST;
		end else if (reg_wr) begin
			if (sel_gate_slot) gate_slot_q <= reg_wdata[3:0]; // [R1]
			if (sel_dom_end)   domain_end_q <= reg_wdata; // [R2]
			if (sel_partial_shutdown_pointer) partial_down_q <= reg_wdata; // [R3]
			if (sel_gate_ctrl) gate_ctrl_q <= reg_wdata;
			if (sel_rst_time)  reset_timing_q <= reg_wdata;
		end
	end

	// slot duration comes from outside the register set, held when loaded
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			slot_code_q <= 4'h0;
		end else if (slot_duration_code_in) begin
			slot_code_q <= slot_duration_code;
		end
	end

	// ****************************************
	// field decode
	// ****************************************
	wire [3:0] power_end     = domain_end_q[HI_NIB_LSB +: 4];
	wire [3:0] system_end    = domain_end_q[3:0];
	wire [3:0] part_stop     = partial_down_q[HI_NIB_LSB +: 4];
	wire [3:0] secondary_end = partial_down_q[3:0];
	wire [1:0] gate_dir      = gate_ctrl_q[GATE_DIR_LSB +: 2];
	wire       gate_tmo_en   = gate_ctrl_q[GATE_TIMEOUT_BIT];
	wire       gate_kind_tmr = gate_ctrl_q[GATE_KIND_BIT];
	wire [3:0] gate_code     = gate_ctrl_q[3:0];
	wire [1:0] rst_trig      = reset_timing_q[RST_TRIG_LSB +: 2];
	wire [5:0] rst_code      = reset_timing_q[5:0];

	// the up run ends at the furthest of the three domain pointers
	wire [3:0] up_hi1 = (power_end > system_end) ? power_end : system_end;
	wire [3:0] up_end = (secondary_end > up_hi1) ? secondary_end : up_hi1; // [R2] [R3]

	// ****************************************
	// timers
	// ****************************************
	logic slot_start, gate_start, tmo_start, rst_start, seq_abort;
	logic slot_done, gate_done, tmo_done, rst_done;

	// no abort here: leaving a gate starts this timer in the same cycle
	swrt_timer #(.UNIT_CYC(SLOT_CYC)) u_slot_tmr (
		.clk    (clk),
		.resetn (resetn),
		.start  (slot_start),
		.abort  (1'b0),
		.units  (slot_units(slot_code_q)), // [R12]
		.busy_q (),
		.done_q (slot_done)
	);

	swrt_timer #(.UNIT_CYC(GATE_CYC)) u_gate_tmr (
		.clk    (clk),
		.resetn (resetn),
		.start  (gate_start),
		.abort  (seq_abort),
		.units  (gate_units(gate_code)), // [R7]
		.busy_q (),
		.done_q (gate_done)
	);

	swrt_timer #(.UNIT_CYC(TIMEOUT_CYC)) u_tmo_tmr (
		.clk    (clk),
		.resetn (resetn),
		.start  (tmo_start),
		.abort  (seq_abort),
		.units  (16'h0001),
		.busy_q (),
		.done_q (tmo_done)
	);

	swrt_timer #(.UNIT_CYC(RESET_CYC)) u_rst_tmr (
		.clk    (clk),
		.resetn (resetn),
		.start  (rst_start),
		.abort  (1'b0),
		.units  (reset_units(rst_code)), // [R10]
		.busy_q (),
		.done_q (rst_done)
	);

	// ****************************************
	// sequencer
	// ****************************************
	typedef enum logic [1:0] {SWRT_IDLE, SWRT_SLOT, SWRT_GATE} swrt_state_e;

	swrt_state_e state_q, state_d;
	logic [3:0]  slot_d;
	logic        down_d, busy_d, step_d, wait_d, tmo_flag_d;
	logic        system_domain_up_d, power_domain_up_d, sec_up_d;
	logic        stop_at_part_q, stop_at_part_d;
	logic        system_domain_up_evt, power_domain_up_evt;

	wire [3:0] down_stop  = stop_at_part_q ? part_stop : 4'h0;
	wire       gate_here  = (slot_q == gate_slot_q) &&
	                        (seq_down_q ? gate_dir[DIR_DOWN_BIT] : gate_dir[DIR_UP_BIT]); // [R1] [R4]
	wire       last_slot  = seq_down_q ? (slot_q == down_stop) : (slot_q == up_end);
	wire       pin_ok     = !gate_kind_tmr && gate_input_pin; // [R6]
	wire       tmr_ok     = gate_kind_tmr && gate_done; // [R6]
	wire       tmo_hit    = !gate_kind_tmr && gate_tmo_en && tmo_done && !gate_input_pin; // [R5]
	wire       gate_leave = pin_ok || tmr_ok || tmo_hit; // [R13]
	wire       start_up   = !seq_busy_q && power_up_req;
	wire       start_down = !seq_busy_q && !start_up && (power_down_req || partial_down_req);

	always_comb begin
		state_d        = state_q;
		slot_d         = slot_q;
		down_d         = seq_down_q;
		busy_d         = seq_busy_q;
		step_d         = 1'b0;
		wait_d         = gate_waiting_q;
		tmo_flag_d     = gate_timeout_q;
		system_domain_up_d       = system_domain_up_q;
		power_domain_up_d       = power_domain_up_q;
		sec_up_d       = secondary_power_domain_up_q;
		stop_at_part_d = stop_at_part_q;
		slot_start     = 1'b0;
		gate_start     = 1'b0;
		tmo_start      = 1'b0;
		seq_abort      = 1'b0;
		system_domain_up_evt     = 1'b0;
		power_domain_up_evt     = 1'b0;
		case (state_q)
			SWRT_IDLE: begin
				if (start_up) begin
					state_d    = SWRT_SLOT;
					slot_d     = 4'h0;
					down_d     = 1'b0;
					busy_d     = 1'b1;
					step_d     = 1'b1;
					tmo_flag_d = 1'b0;
					slot_start = 1'b1;
				end else if (start_down) begin
					// downward run starts from the top slot of the up run
					state_d        = SWRT_SLOT;
					slot_d         = up_end;
					down_d         = 1'b1;
					busy_d         = 1'b1;
					step_d         = 1'b1;
					tmo_flag_d     = 1'b0;
					stop_at_part_d = partial_down_req && !power_down_req; // [R3]
					slot_start     = 1'b1;
					system_domain_up_d       = 1'b0;
					power_domain_up_d       = 1'b0;
					sec_up_d       = 1'b0;
				end
			end
			SWRT_SLOT: begin
				if (slot_done) begin
					if (!seq_down_q && slot_q == system_end) begin
						system_domain_up_d   = 1'b1;
						system_domain_up_evt = 1'b1; // [R2]
					end
					if (!seq_down_q && slot_q == power_end) begin
						power_domain_up_d   = 1'b1;
						power_domain_up_evt = 1'b1; // [R2]
					end
					if (!seq_down_q && slot_q == secondary_end) begin
						sec_up_d = 1'b1; // [R3]
					end
					if (gate_here) begin
						state_d    = SWRT_GATE;
						wait_d     = 1'b1;
						gate_start = gate_kind_tmr;
						tmo_start  = !gate_kind_tmr && gate_tmo_en;
					end else if (last_slot) begin
						state_d = SWRT_IDLE;
						busy_d  = 1'b0;
					end else begin
						slot_d     = seq_down_q ? slot_q - 4'h1 : slot_q + 4'h1; // [R11]
						step_d     = 1'b1;
						slot_start = 1'b1;
					end
				end
			end
			SWRT_GATE: begin
				if (gate_leave) begin
					wait_d     = 1'b0;
					tmo_flag_d = tmo_hit || gate_timeout_q; // [R13]
					seq_abort  = 1'b1;
					if (last_slot) begin
						state_d = SWRT_IDLE;
						busy_d  = 1'b0;
					end else begin
						state_d    = SWRT_SLOT;
						slot_d     = seq_down_q ? slot_q - 4'h1 : slot_q + 4'h1; // [R11]
						step_d     = 1'b1;
						slot_start = 1'b1;
					end
				end
			end
			default: begin
				state_d = SWRT_IDLE;
				busy_d  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q                     <= SWRT_IDLE;
			slot_q                      <= 4'h0;
			seq_down_q                  <= 1'b0;
			seq_busy_q                  <= 1'b0;
			slot_step_q                 <= 1'b0;
			gate_waiting_q              <= 1'b0;
			gate_timeout_q              <= 1'b0;
			system_domain_up_q          <= 1'b0;
			power_domain_up_q           <= 1'b0;
			secondary_power_domain_up_q <= 1'b0;
			stop_at_part_q              <= 1'b0;
		end else begin
			state_q                     <= state_d;
			slot_q                      <= slot_d;
			seq_down_q                  <= down_d;
			seq_busy_q                  <= busy_d;
			slot_step_q                 <= step_d;
			gate_waiting_q              <= wait_d;
			gate_timeout_q              <= tmo_flag_d;
			system_domain_up_q          <= system_domain_up_d;
			power_domain_up_q           <= power_domain_up_d;
			secondary_power_domain_up_q <= sec_up_d;
			stop_at_part_q              <= stop_at_part_d;
		end
	end

	// ****************************************
	// reset-release timer
	// ****************************************
	// leave-reset trigger assumes the reset output mode select is 0
	logic rst_event;

	always_comb begin
		case (swrt_trig_e'(rst_trig))
			SWRT_TRIG_WAKE:    rst_event = external_wake_event; // [R8]
			SWRT_TRIG_SYSTEM_DOMAIN_UP:  rst_event = system_domain_up_evt; // [R8]
			SWRT_TRIG_POWER_DOMAIN_UP:  rst_event = power_domain_up_evt; // [R8]
			default:           rst_event = reset_state_exit; // [R8] [R9]
		endcase
	end

	assign rst_start = rst_event;

	// a new trigger restarts the delay; a down run takes release away
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reset_release_q <= 1'b0;
		end else if (rst_done) begin
			reset_release_q <= 1'b1; // [R10]
		end else if (start_down || rst_event) begin
			reset_release_q <= 1'b0;
		end
	end

	// ****************************************
	// read port
	// ****************************************
	// reserved and unmapped offsets read zero; data valid one cycle only
	wire [7:0] status_val = {reset_release_q, gate_timeout_q, gate_waiting_q, seq_busy_q, slot_q};
	logic [7:0] rd_val;

	always_comb begin
		if (sel_gate_slot) begin
			rd_val = {4'h0, gate_slot_q};
		end else if (sel_dom_end) begin
			rd_val = domain_end_q;
		end else if (sel_partial_shutdown_pointer) begin
			rd_val = partial_down_q;
		end else if (sel_gate_ctrl) begin
			rd_val = gate_ctrl_q;
		end else if (sel_rst_time) begin
			rd_val = reset_timing_q;
		end else if (sel_status) begin
			rd_val = status_val;
		end else begin
			rd_val = 8'h00;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata_q <= 8'h00;
		end else begin
			reg_rdata_q <= reg_rd ? rd_val : 8'h00;
		end
	end

endmodule

// ---- tb/swrt_checker.sv ----
/*
 * swrt_checker: port-level checks of swrt_top, bound into every instance.
 * Assumes the hand-over timing: read data one cycle after the strobe.
 */
`timescale 1ns/1ps
module swrt_checker import swrt_pkg::*; #(
	parameter int SLOT_CYC    = 2,
	parameter int GATE_CYC    = 3,
	parameter int TIMEOUT_CYC = 20,
	parameter int RESET_CYC   = 4
) (
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       reg_rd,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata_q,
	input wire logic       gate_input_pin,
	input wire logic [3:0] slot_q,
	input wire logic       slot_step_q,
	input wire logic       seq_busy_q,
	input wire logic       seq_down_q,
	input wire logic       gate_waiting_q,
	input wire logic       gate_timeout_q
);
	// ****************************************
	// properties
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// shadow of the gate kind bit: the pin is ignored in timer mode
	logic kind_tmr_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			kind_tmr_q <= 1'b0;
		end else if (reg_wr && reg_addr == GATE_CONTROL_OFS) begin
			kind_tmr_q <= reg_wdata[GATE_KIND_BIT];
		end
	end
	// shortest slot is one unit plus the done registration
	sequence s_step_gap;
		!slot_step_q [*2];
	endsequence
	sequence s_run_start;
		$rose(seq_busy_q) ##0 slot_step_q;
	endsequence
	a_rd_quiet: assert property (!reg_rd |=> reg_rdata_q == 8'h00)
		else $error("read data outside read slot");
	a_up_start: assert property ($rose(seq_busy_q) && !seq_down_q |-> s_run_start ##0 slot_q == 4'h0)
		else $error("up run not at slot zero");
	a_down_start: assert property ($rose(seq_busy_q) && seq_down_q |-> s_run_start)
		else $error("down run without slot step");
	a_up_order: assert property (slot_step_q && !seq_down_q && !$rose(seq_busy_q)
		|-> slot_q == $past(slot_q) + 4'h1) else $error("up slot order");
	a_down_order: assert property (slot_step_q && seq_down_q && !$rose(seq_busy_q)
		|-> slot_q == $past(slot_q) - 4'h1) else $error("down slot order");
	a_slot_length: assert property (slot_step_q |=> s_step_gap)
		else $error("slot too short");
	a_gate_busy: assert property (gate_waiting_q |-> seq_busy_q)
		else $error("gate wait while idle");
	a_pin_leave: assert property (gate_waiting_q && gate_input_pin && !kind_tmr_q
		|=> !gate_waiting_q) else $error("gate held with pin active");
	a_timeout_cause: assert property ($rose(gate_timeout_q)
		|-> $past(gate_waiting_q) && !$past(gate_input_pin)) else $error("bad timeout");
endmodule

bind swrt_top swrt_checker #(.SLOT_CYC(SLOT_CYC), .GATE_CYC(GATE_CYC),
	.TIMEOUT_CYC(TIMEOUT_CYC), .RESET_CYC(RESET_CYC)) swrt_checker_inst (.*);

// ---- tb/swrt_tb.sv ----
/*
 * swrt_tb: self-checking bench for swrt_top with shortened timer units.
 * Assumes the package timing and a checker bound to the design.
 */
`timescale 1ns/1ps
module swrt_tb;
	logic       clk, resetn, reg_wr, reg_rd, rd_d, up, dn, pd, wake, rexit, ld, pin;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_q, d;
	logic [3:0] code, slot_q;
	logic       step, busy, down, gw_q, gto, system_domain_up, power_domain_up, sec_up, rel;
	logic [7:0] rd_exp[$];
	logic [3:0] slot_exp[$];
	logic [7:0] ofs[10] = '{8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'h98, 8'h99, 8'hA0, 8'h50};
	int         n_fail, compares, cyc, gw, seed, rc, su;

	swrt_top #(.SLOT_CYC(2), .GATE_CYC(3), .TIMEOUT_CYC(20), .RESET_CYC(4)) swrt_top_inst (
		.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.power_up_req(up), .power_down_req(dn), .partial_down_req(pd),
		.external_wake_event(wake), .reset_state_exit(rexit),
		.slot_duration_code_in(ld), .slot_duration_code(code), .gate_input_pin(pin),
		.slot_q(slot_q), .slot_step_q(step), .seq_busy_q(busy), .seq_down_q(down),
		.gate_waiting_q(gw_q), .gate_timeout_q(gto), .system_domain_up_q(system_domain_up),
		.power_domain_up_q(power_domain_up), .secondary_power_domain_up_q(sec_up),
		.reset_release_q(rel));

	// ****************************************
	// tasks
	// ****************************************
	task automatic end_sim();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// read: dv is the expected value, checked by the monitor
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] dv);
		reg_addr <= a;
		reg_wdata <= dv;
		reg_wr <= w;
		reg_rd <= !w;
		if (!w) rd_exp.push_back(dv);
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic run(input logic [2:0] req, input logic hold, input int first, input int last);
		int n;
		for (int s = first; s != last; s += (last > first) ? 1 : -1) slot_exp.push_back(4'(s));
		slot_exp.push_back(4'(last));
		gw = 0;
		{pd, dn, up} <= req;
		@(posedge clk);
		{pd, dn, up} <= 3'b000;
		if (hold) begin
			repeat (60) @(posedge clk);
			check({7'h00, gw_q}, 8'h01);
			pin <= 1'b1;
		end
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (busy !== 1'b0 || n < 2);
		pin <= 1'b0;
		rc = n;
		check({7'h00, down}, {7'h00, req[2] | req[1]});
	endtask
	task automatic rtime(input logic [7:0] v, input int units);
		int n;
		bus(1'b1, 8'h99, v);
		wake <= !v[7];
		rexit <= v[7];
		@(posedge clk);
		wake <= 1'b0;
		rexit <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rel !== 1'b1 && n < 600);
		check(8'(n >= units * 4 && n <= units * 4 + 3), 8'h01);
	endtask

	// ****************************************
	// clock, monitor, sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		rd_d <= reg_rd;
		cyc++;
		if (gw_q === 1'b1) gw++;
		if (rd_d) check(reg_rdata_q, rd_exp.pop_front());
		if (step) check({4'h0, slot_q}, {4'h0, slot_exp.pop_front()});
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
	end
	initial begin
		seed = 32'h49b0;
		{resetn, reg_wr, reg_rd, up, dn, pd, wake, rexit, ld, pin} = '0;
		{reg_addr, reg_wdata, code} = '0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		ld <= 1'b1;
		@(posedge clk);
		ld <= 1'b0;
		foreach (ofs[i]) bus(1'b0, ofs[i], 8'h00);
		foreach (ofs[i]) begin
			d = 8'($random(seed));
			bus(1'b1, ofs[i], d);
			bus(1'b0, ofs[i], (ofs[i] == 8'h92) ? (d & 8'h0F) :
				(ofs[i] inside {8'h95, 8'h96, 8'h97, 8'h99}) ? d : 8'h00);
		end
		$display("test registers done");
		bus(1'b1, 8'h95, 8'h21);
		bus(1'b1, 8'h96, 8'h13);
		bus(1'b1, 8'h97, 8'h00);
		bus(1'b1, 8'h99, 8'h41);
		run(3'b001, 1'b0, 0, 3);
		repeat (8) @(posedge clk);
		check({4'h0, system_domain_up, power_domain_up, sec_up, rel}, 8'h0F);
		run(3'b100, 1'b0, 3, 1);
		check({4'h0, system_domain_up, power_domain_up, sec_up, rel}, 8'h00);
		$display("test domains done");
		bus(1'b1, 8'h92, 8'h01);
		bus(1'b1, 8'h97, 8'h40);
		run(3'b001, 1'b1, 0, 3);
		check({7'h00, gto}, 8'h00);
		bus(1'b1, 8'h97, 8'hE0);
		run(3'b010, 1'b0, 3, 0);
		check({7'h00, gto}, 8'h01);
		check(8'(gw >= 20 && gw <= 23), 8'h01);
		bus(1'b1, 8'h97, 8'h80);
		bus(1'b1, 8'h99, 8'h81);
		run(3'b001, 1'b0, 0, 3);
		repeat (8) @(posedge clk);
		check({6'h00, gw_q, rel}, 8'h01);
		bus(1'b1, 8'h97, 8'h40);
		run(3'b010, 1'b0, 3, 0);
		check(8'(gw), 8'h00);
		$display("test gate pin done");
		for (int k = 1; k < 4; k += 2) begin
			bus(1'b1, 8'h97, 8'hD0 | 8'(k));
			run(3'b001, 1'b0, 0, 3);
			check(8'(gw >= 3 * (1 << (k - 1)) && gw <= 3 * (1 << (k - 1)) + 3), 8'h01);
		end
		$display("test gate timer done");
		bus(1'b1, 8'h97, 8'h00);
		for (int k = 9; k < 13; k += 3) begin
			// 384 us and 1.024 ms slots, in 32 us units
			su = (k == 9) ? 12 : 32;
			code <= 4'(k);
			ld <= 1'b1;
			@(posedge clk);
			ld <= 1'b0;
			run(3'b001, 1'b0, 0, 3);
			check(8'(rc >= 8 * su && rc <= 8 * su + 8), 8'h01);
		end
		$display("test slot time done");
		rtime(8'h00, 0);
		rtime(8'h20, 32);
		rtime(8'h21, 64);
		// reset output mode select sits outside this block, taken as 0
		rtime(8'hC1, 1);
		$display("test reset timer done");
		repeat (4) @(posedge clk);
		end_sim();
	end
endmodule
